// >>> hdl/ccfl_pkg.sv
// Constants for the cache control field logic: register fields, sizes.
// Assumes a 128-line direct-mapped cache with 16-byte lines.
package ccfl_pkg;
   localparam int CTL_W = 32;
   localparam int IDX_W = 7;
   localparam int LINES = 128;
   localparam int HALF_LINES = 64;
   localparam int BIT_CACHE_EN = 31;
   localparam int BIT_PUSH_INV_DIS = 28;
   localparam int BIT_FREEZE = 27;
   localparam int BIT_INV_ALL = 24;
   localparam int BIT_INSTR_OFF = 23;
   localparam int BIT_DATA_OFF = 22;
   localparam int BIT_INV_I = 21;
   localparam int BIT_INV_D = 20;
   localparam int BIT_NC_BURST = 10;
   localparam int LFS_LSB = 0;
   localparam int LFS_W = 2;
   localparam int ADDR_IDX_LSB = 4;
   localparam logic [CTL_W-1:0] CTL_RESET = 32'h0000_0000;
   // Bits kept in the register; the invalidate-all bit is a command only.
   localparam logic [CTL_W-1:0] CTL_KEEP_MASK = 32'h98F0_0403;
   localparam logic [IDX_W-1:0] LAST_FULL = 7'h7F;
   localparam logic [IDX_W-1:0] LAST_HALF = 7'h3F;
   typedef enum logic [1:0] {CCFL_IDLE, CCFL_SWEEP, CCFL_FILL} ccfl_state_t;
endpackage

// >>> hdl/ccfl_vld_if.sv
// Valid-bit array port between the control logic and the valid memory.
// Assumes one write port and one registered read port.
`timescale 1ns/1ps
`default_nettype none
interface ccfl_vld_if;
   import ccfl_pkg::*;
   logic [IDX_W-1:0] rd_idx;
   logic rd_data;
   logic we;
   logic [IDX_W-1:0] wr_idx;
   logic wr_val;
   modport ctl (output rd_idx, we, wr_idx, wr_val, input rd_data);
   modport mem (input rd_idx, we, wr_idx, wr_val, output rd_data);
endinterface
`default_nettype wire

// >>> hdl/ccfl_valid_mem.sv
// Valid bit per cache line with registered read data.
// Assumes software clears the array before it enables the cache.
`timescale 1ns/1ps
`default_nettype none
module ccfl_valid_mem #(
   parameter int LINES_P = ccfl_pkg::LINES
) (
   input wire logic mclk_i,
   input wire logic rst_i,
   ccfl_vld_if.mem vld
);
   import ccfl_pkg::*;
   logic [LINES_P-1:0] bits_r;
   logic rd_r;

   // The line index is fixed at seven bits, so only one size is served.
   if (LINES_P != LINES)
   begin : g_bad_size
      $error("ccfl_valid_mem: LINES_P must equal LINES");
   end

   // The array itself is not reset; it holds no control state.
   always_ff @(posedge mclk_i)
   begin
      if (vld.we)
      begin
         bits_r[vld.wr_idx] <= vld.wr_val;
      end
   end

   // Read data come out of a register one cycle after the index.
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         rd_r <= 1'b0;
      end
      else
      begin
         rd_r <= bits_r[vld.rd_idx];
      end
   end

   assign vld.rd_data = rd_r;
endmodule
`default_nettype wire

// >>> hdl/ccfl_top.sv
// Cache control register fields and the line valid bookkeeping they steer.
// Assumes the core writes the register by a move-to-control strobe.
`timescale 1ns/1ps
`default_nettype none
module ccfl_top (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic ctl_wr_i,
   input wire logic [ccfl_pkg::CTL_W-1:0] ctl_wdata_i,
   output logic [ccfl_pkg::CTL_W-1:0] ctl_rdata_o,
   input wire logic push_i,
   input wire logic [31:0] push_addr_i,
   input wire logic fill_i,
   input wire logic [31:0] fill_addr_i,
   input wire logic fill_instr_i,
   input wire logic fill_cacheable_i,
   output logic fill_write_o,
   output logic [ccfl_pkg::IDX_W-1:0] fill_idx_o,
   output logic fill_done_o,
   output logic array_en_o,
   output logic icache_on_o,
   output logic dcache_on_o,
   output logic split_o,
   output logic nc_burst_o,
   output logic [ccfl_pkg::LFS_W-1:0] line_fill_size_o,
   output logic busy_o
);
   import ccfl_pkg::*;

   ccfl_vld_if vld ();

   ccfl_state_t state_r, state_nxt;
   logic [CTL_W-1:0] ctl_r, ctl_nxt, wd;
   logic [IDX_W-1:0] cnt_r, cnt_nxt, last_r, last_nxt;
   logic half_r, half_nxt, msb_r, msb_nxt;
   logic [IDX_W-1:0] fidx_r, fidx_nxt;
   logic fok_r, fok_nxt, fwr_nxt, fdone_nxt;
   logic split_now, sweep_go, w_split, idle;

   ccfl_valid_mem #(.LINES_P(LINES)) u_mem (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .vld(vld)
   );

   // Line index: full address bits, or a type-selected half when split.
   function automatic logic [IDX_W-1:0] line_idx(input logic [31:0] a,
      input logic spl, input logic instr);
      line_idx = spl ? {instr, a[ADDR_IDX_LSB +: IDX_W-1]}
                     : a[ADDR_IDX_LSB +: IDX_W];
   endfunction

   assign idle = (state_r == CCFL_IDLE);
   assign split_now = !ctl_r[BIT_INSTR_OFF] && !ctl_r[BIT_DATA_OFF];

   // Register write, sweep start, push and fill requests.
   always_comb
   begin
      state_nxt = state_r;
      ctl_nxt = ctl_r;
      cnt_nxt = cnt_r;
      last_nxt = last_r;
      half_nxt = half_r;
      msb_nxt = msb_r;
      fidx_nxt = fidx_r;
      fok_nxt = fok_r;
      fwr_nxt = 1'b0;
      fdone_nxt = 1'b0;
      sweep_go = 1'b0;
      vld.we = 1'b0;
      vld.wr_idx = '0;
      vld.wr_val = 1'b0;
      vld.rd_idx = fidx_r;
      wd = ctl_wdata_i & CTL_KEEP_MASK;
      w_split = !wd[BIT_INSTR_OFF] && !wd[BIT_DATA_OFF];
      if (!w_split)
      begin
         wd[BIT_INV_I] = 1'b0;
         wd[BIT_INV_D] = 1'b0;
      end
      if (ctl_wr_i)
      begin
         ctl_nxt = wd;
      end
      unique case (state_r)
         CCFL_IDLE:
         begin
            if (ctl_wr_i && ctl_wdata_i[BIT_INV_ALL])
            begin
               // Scope from the new value; enable bit plays no part.
               sweep_go = 1'b1;
               cnt_nxt = '0;
               half_nxt = 1'b0;
               msb_nxt = 1'b0;
               last_nxt = LAST_FULL;
               if (w_split && (wd[BIT_INV_I] ^ wd[BIT_INV_D]))
               begin
                  half_nxt = 1'b1;
                  msb_nxt = wd[BIT_INV_I];
                  last_nxt = LAST_HALF;
               end
               if (w_split && wd[BIT_INV_I] && wd[BIT_INV_D])
               begin
                  sweep_go = 1'b0;
               end
               if (sweep_go)
               begin
                  state_nxt = CCFL_SWEEP;
               end
            end
            else if (push_i)
            begin
               if (!ctl_r[BIT_PUSH_INV_DIS])
               begin
                  vld.we = 1'b1;
                  vld.wr_idx = push_addr_i[ADDR_IDX_LSB +: IDX_W];
               end
            end
            else if (fill_i)
            begin
               fidx_nxt = line_idx(fill_addr_i, split_now, fill_instr_i);
               vld.rd_idx = fidx_nxt;
               fok_nxt = fill_cacheable_i && ctl_r[BIT_CACHE_EN]
                  && (fill_instr_i ? !ctl_r[BIT_INSTR_OFF]
                                   : !ctl_r[BIT_DATA_OFF]);
               state_nxt = CCFL_FILL;
            end
         end
         CCFL_SWEEP:
         begin
            vld.we = 1'b1;
            vld.wr_idx = half_r ? {msb_r, cnt_r[IDX_W-2:0]} : cnt_r;
            cnt_nxt = cnt_r + 1'b1;
            if (cnt_r == last_r)
            begin
               state_nxt = CCFL_IDLE;
            end
         end
         CCFL_FILL:
         begin
            // Frozen valid lines stay; invalid ones may still be filled.
            fwr_nxt = fok_r && !(ctl_r[BIT_FREEZE] && vld.rd_data);
            fdone_nxt = 1'b1;
            vld.we = fwr_nxt;
            vld.wr_idx = fidx_r;
            vld.wr_val = 1'b1;
            state_nxt = CCFL_IDLE;
         end
         default:
         begin
            state_nxt = CCFL_IDLE;
         end
      endcase
   end

   // State and output registers; outputs follow the stored fields.
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         state_r <= CCFL_IDLE;
         ctl_r <= CTL_RESET;
         cnt_r <= '0;
         last_r <= '0;
         half_r <= 1'b0;
         msb_r <= 1'b0;
         fidx_r <= '0;
         fok_r <= 1'b0;
         ctl_rdata_o <= CTL_RESET;
         fill_write_o <= 1'b0;
         fill_idx_o <= '0;
         fill_done_o <= 1'b0;
         array_en_o <= 1'b0;
         icache_on_o <= 1'b0;
         dcache_on_o <= 1'b0;
         split_o <= 1'b0;
         nc_burst_o <= 1'b0;
         line_fill_size_o <= '0;
         busy_o <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         ctl_r <= ctl_nxt;
         cnt_r <= cnt_nxt;
         last_r <= last_nxt;
         half_r <= half_nxt;
         msb_r <= msb_nxt;
         fidx_r <= fidx_nxt;
         fok_r <= fok_nxt;
         ctl_rdata_o <= ctl_nxt;
         fill_write_o <= fwr_nxt;
         fill_idx_o <= fidx_r;
         fill_done_o <= fdone_nxt;
         array_en_o <= ctl_nxt[BIT_CACHE_EN];
         icache_on_o <= ctl_nxt[BIT_CACHE_EN] && !ctl_nxt[BIT_INSTR_OFF];
         dcache_on_o <= ctl_nxt[BIT_CACHE_EN] && !ctl_nxt[BIT_DATA_OFF];
         split_o <= ctl_nxt[BIT_CACHE_EN] && !ctl_nxt[BIT_INSTR_OFF]
            && !ctl_nxt[BIT_DATA_OFF];
         nc_burst_o <= ctl_nxt[BIT_NC_BURST];
         line_fill_size_o <= ctl_nxt[LFS_LSB +: LFS_W];
         busy_o <= (state_nxt != CCFL_IDLE);
      end
   end

   // Length of each sweep stretch, watched by the sweep check.
   logic [7:0] blen_r;
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         blen_r <= '0;
      end
      else
      begin
         blen_r <= (state_r == CCFL_SWEEP) ? blen_r + 8'h01 : 8'h00;
      end
   end

   // Checks on push, fill, sweep and register behaviour.
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);

   AST_PUSH_CLR: assert property (idle && !ctl_wr_i && push_i
      && !ctl_r[BIT_PUSH_INV_DIS] |-> vld.we && !vld.wr_val
      && vld.wr_idx == push_addr_i[ADDR_IDX_LSB +: IDX_W])
      else $error("line push did not clear its entry");
   AST_PUSH_NOP: assert property (idle && !ctl_wr_i && push_i
      && ctl_r[BIT_PUSH_INV_DIS] |-> !vld.we)
      else $error("disabled line push touched the array");
   AST_FRZ_KEEP: assert property (state_r == CCFL_FILL
      && ctl_r[BIT_FREEZE] && vld.rd_data |=> !fill_write_o)
      else $error("frozen valid line overwritten");
   AST_FRZ_FILL: assert property (state_r == CCFL_FILL && fok_r
      && !vld.rd_data |=> fill_write_o && fill_done_o)
      else $error("invalid line not filled");
   AST_INV_START: assert property (idle && ctl_wr_i
      && ctl_wdata_i[BIT_INV_ALL] && !ctl_wdata_i[BIT_INV_I]
      |=> busy_o && state_r == CCFL_SWEEP)
      else $error("invalidate-all did not start");
   AST_SWEEP_LEN: assert property (state_r == CCFL_SWEEP
      && state_nxt == CCFL_IDLE |-> blen_r == (half_r ? 8'h3F : 8'h7F))
      else $error("sweep length wrong");
   AST_RD_ZERO: assert property (!ctl_rdata_o[BIT_INV_ALL])
      else $error("invalidate-all bit read as one");
   AST_HALF_GATE: assert property (!split_now
      |-> !ctl_r[BIT_INV_I] && !ctl_r[BIT_INV_D])
      else $error("half-invalidate bit set outside split mode");
   AST_NC_NOWR: assert property (idle && !ctl_wr_i && !push_i
      && fill_i && !fill_cacheable_i |=> ##1 !fill_write_o)
      else $error("non-cacheable line written to array");
endmodule
`default_nettype wire

// >>> verif/ccfl_core_model.sv
// Core-side model: supervisor register writes, line pushes and line fills.
// Assumes the block samples its inputs on the rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module ccfl_core_model (
   input wire logic mclk_i,
   output logic ctl_wr_o,
   output logic [31:0] ctl_wdata_o,
   output logic push_o,
   output logic [31:0] push_addr_o,
   output logic fill_o,
   output logic [31:0] fill_addr_o,
   output logic fill_instr_o,
   output logic fill_cacheable_o
);
   // Reserved positions that supervisor software always leaves at zero.
   localparam logic [31:0] RSVD = 32'h660F_F800;

   // All requests idle at time zero.
   initial
   begin
      {ctl_wr_o, push_o, fill_o, fill_instr_o, fill_cacheable_o} = 5'h00;
      {ctl_wdata_o, push_addr_o, fill_addr_o} = 96'h0;
   end

   // One write pulse; released data is inverted so stale values never match.
   task automatic wr(input logic [31:0] d);
      @(negedge mclk_i);
      ctl_wr_o = 1'b1;
      ctl_wdata_o = d & ~RSVD;
      @(negedge mclk_i);
      ctl_wr_o = 1'b0;
      ctl_wdata_o = ~ctl_wdata_o;
   endtask

   // One line push pulse with its address.
   task automatic push(input logic [31:0] a);
      @(negedge mclk_i);
      push_o = 1'b1;
      push_addr_o = a;
      @(negedge mclk_i);
      push_o = 1'b0;
      push_addr_o = ~a;
   endtask

   // One fill request from the line-fill buffer with its qualifiers.
   task automatic fill(input logic [31:0] a, input logic ins, input logic c);
      @(negedge mclk_i);
      fill_o = 1'b1;
      fill_addr_o = a;
      fill_instr_o = ins;
      fill_cacheable_o = c;
      @(negedge mclk_i);
      fill_o = 1'b0;
      fill_addr_o = ~a;
      fill_instr_o = ~ins;
   endtask
endmodule
`default_nettype wire

// >>> verif/tb_top.sv
// Self-checking bench for the cache control field logic.
// Assumes the core model drives every request input of the block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import ccfl_pkg::*;
   logic mclk_i = 1'b0;
   logic rst_i = 1'b1;
   logic ctl_wr_i, push_i, fill_i, fill_instr_i, fill_cacheable_i;
   logic [31:0] ctl_wdata_i, push_addr_i, fill_addr_i, ctl_rdata_o;
   logic fill_write_o, fill_done_o, array_en_o, icache_on_o, dcache_on_o;
   logic split_o, nc_burst_o, busy_o;
   logic [6:0] fill_idx_o;
   logic [1:0] line_fill_size_o;
   logic [15:0] cyc = 16'h0000;
   int fail_count = 0;
   int cmp_count = 0;

   // Core clock, 20 ns period.
   always #10 mclk_i = ~mclk_i;

   ccfl_core_model core (.mclk_i, .ctl_wr_o(ctl_wr_i),
      .ctl_wdata_o(ctl_wdata_i), .push_o(push_i), .push_addr_o(push_addr_i),
      .fill_o(fill_i), .fill_addr_o(fill_addr_i),
      .fill_instr_o(fill_instr_i), .fill_cacheable_o(fill_cacheable_i));

   ccfl_top uut (.mclk_i, .rst_i, .ctl_wr_i, .ctl_wdata_i, .ctl_rdata_o,
      .push_i, .push_addr_i, .fill_i, .fill_addr_i, .fill_instr_i,
      .fill_cacheable_i, .fill_write_o, .fill_idx_o, .fill_done_o,
      .array_en_o, .icache_on_o, .dcache_on_o, .split_o, .nc_burst_o,
      .line_fill_size_o, .busy_o);

   task automatic final_report();
      $display("Checks %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] e,
      input logic [31:0] g);
      cmp_count++;
      if (g !== e)
      begin
         fail_count++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask

   // Writes the register, then compares the image and the config levels.
   task automatic cfg(input logic [31:0] w, input logic [31:0] e);
      core.wr(w);
      @(negedge mclk_i);
      chk("rdata", e, ctl_rdata_o);
      chk("cfg_out", {25'h0, e[31], e[31] & ~e[23], e[31] & ~e[22],
         e[31] & ~e[23] & ~e[22], e[10], e[1:0]}, {25'h0, array_en_o,
         icache_on_o, dcache_on_o, split_o, nc_burst_o, line_fill_size_o});
   endtask

   // Starts an invalidate-all and counts the cycles the sweep stays busy.
   task automatic sweep(input logic [31:0] w, input logic [31:0] n_exp);
      logic [31:0] n;
      n = 32'h0;
      core.wr(w);
      repeat (200)
      begin
         if (busy_o === 1'b1)
            n++;
         @(negedge mclk_i);
      end
      chk("sweep_len", n_exp, n);
      chk("inv_bit_read", 32'h0, {31'h0, ctl_rdata_o[BIT_INV_ALL]});
   endtask

   // One fill; the decision is due one cycle after the take edge.
   task automatic fl(input logic [31:0] a, input logic ins, input logic c,
      input logic ew, input logic [6:0] ei);
      core.fill(a, ins, c);
      chk("fill_busy", 32'h1, {31'h0, busy_o});
      @(negedge mclk_i);
      chk("fill_done", 32'h1, {31'h0, fill_done_o});
      chk("fill_write", {31'h0, ew}, {31'h0, fill_write_o});
      chk("fill_idx", {25'h0, ei}, {25'h0, fill_idx_o});
   endtask

   // Cuts a hung run short.
   always @(posedge mclk_i)
   begin
      cyc <= cyc + 16'h0001;
      if (cyc == 16'h1000)
      begin
         fail_count++;
         final_report();
      end
   end

   // Main sequence: invalidate before enabling, then configs and fills.
   initial
   begin
      repeat (4) @(negedge mclk_i);
      rst_i = 1'b0;
      chk("rdata_reset", CTL_RESET, ctl_rdata_o);
      chk("array_en_reset", 32'h0, {31'h0, array_en_o});
      sweep(32'h0100_0000, 32'd128);
      cfg(32'hFEFF_FFFF, 32'h98C0_0403);
      sweep(32'h8170_0000, 32'd128);
      cfg(32'h8030_0401, 32'h8030_0401);
      sweep(32'h8120_0000, 32'd64);
      sweep(32'h8110_0000, 32'd64);
      sweep(32'h8130_0000, 32'd0);
      cfg(32'h8000_0000, 32'h8000_0000);
      fl(32'h0000_0050, 1'b1, 1'b1, 1'b1, 7'h45);
      fl(32'h0000_0050, 1'b0, 1'b1, 1'b1, 7'h05);
      cfg(32'h8800_0000, 32'h8800_0000);
      fl(32'h0000_0050, 1'b0, 1'b1, 1'b0, 7'h05);
      fl(32'h0000_0060, 1'b0, 1'b1, 1'b1, 7'h06);
      core.push(32'h0000_0060);
      fl(32'h0000_0060, 1'b0, 1'b1, 1'b1, 7'h06);
      cfg(32'h9800_0000, 32'h9800_0000);
      core.push(32'h0000_0060);
      fl(32'h0000_0060, 1'b0, 1'b1, 1'b0, 7'h06);
      fl(32'h0000_0070, 1'b0, 1'b0, 1'b0, 7'h07);
      cfg(32'h0000_0000, 32'h0000_0000);
      fl(32'h0000_0080, 1'b0, 1'b1, 1'b0, 7'h08);
      cfg(32'h8080_0000, 32'h8080_0000);
      fl(32'h0000_0090, 1'b1, 1'b1, 1'b0, 7'h09);
      fl(32'h0000_0090, 1'b0, 1'b1, 1'b1, 7'h09);
      cfg(32'h8040_0000, 32'h8040_0000);
      fl(32'h0000_00A0, 1'b0, 1'b1, 1'b0, 7'h0A);
      cfg(32'h8800_0000, 32'h8800_0000);
      fl(32'h0000_00B0, 1'b1, 1'b1, 1'b1, 7'h4B);
      fl(32'h0000_00B0, 1'b0, 1'b1, 1'b1, 7'h0B);
      sweep(32'h8920_0000, 32'd64);
      fl(32'h0000_00B0, 1'b1, 1'b1, 1'b1, 7'h4B);
      fl(32'h0000_00B0, 1'b0, 1'b1, 1'b0, 7'h0B);
      final_report();
   end
endmodule
`default_nettype wire
